// file: src/timer_watchdog_regfile.sv
// Register bank of the 16-bit timer and its watchdog counter.
//
// Operation
// - Privilege-only bits change on a write only while the CPU is in privilege mode.
// - Clear-only bits can only be cleared by software and set-only bits only set.
// - Reset drives bits to their stated reset level, special bits keep their own rule.
// - Once the watchdog reset enable is set, tap and input selects freeze until reset.
// - In the hard watchdog option the selects stay writable and the input select MSB is ignored.
// - Control 2 bit 7 is the set-only watchdog reset enable, bit 6 its interrupt enable.
// - Control 2 bit 5 is the clear-only watchdog overflow flag with special reset.
// - Control 1 holds the timer clock select in bits 2..0 and watchdog selects in bits 7..4.
// - Control 4 bit 7 selects dual compare or capture/compare and shapes controls 3 and 4.
// - Control 3 holds clear-only edge, compare-2, compare-1 flags and their enables.
// - Each timer pin has a read-only level, output data, function select and direction.
// - The priority register holds privileged self-test and priority bits, reset to zero.
`timescale 1ns/1ps

module timer_watchdog_regfile
  import timer_regs_pkg::*;
#(
  parameter wdog_option_t WDOG_OPTION = WDOG_STANDARD
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Peripheral-file access.
  input wire pf_req_t pf_req_i,
  output logic [7:0] pf_rdata_o,
  // Values from the counting logic.
  input wire logic [15:0] timer_count_i,
  input wire logic [15:0] capture_value_i,
  input wire logic capture_load_i,
  input wire logic [15:0] wdog_count_i,
  input wire timer_events_t events_i,
  // Watchdog reset cause, sampled for the special reset of the overflow flag.
  input wire logic wdog_reset_cause_i,
  // Pin levels.
  input wire logic event_pin_i,
  input wire logic pwm_pin_i,
  input wire logic capture_reset_pin_i,
  // Controls toward the counting logic.
  output logic [15:0] compare_value_o,
  output logic [15:0] capture_compare_o,
  output logic [7:0] control_one_o,
  output logic [7:0] control_two_o,
  output logic [7:0] control_three_o,
  output logic [7:0] control_four_o,
  output logic [7:0] priority_o,
  output logic timer_soft_clear_o,
  output logic wdog_key_write_o,
  output logic [7:0] wdog_key_o,
  // Pin controls.
  output pin_ctrl_t event_pin_ctrl_o,
  output pin_ctrl_t pwm_pin_ctrl_o,
  output pin_ctrl_t capture_reset_pin_ctrl_o
);

  // ==========================================================================
  // Access decode
  // ==========================================================================
  logic [15:0] compare_ff;
  logic [15:0] capcmp_ff;
  logic [7:0] ctl1_ff;
  logic [7:0] ctl2_ff;
  logic [7:0] ctl3_ff;
  logic [7:0] ctl4_ff;
  logic [7:0] pc1_ff;
  logic [7:0] pc2_ff;
  logic [7:0] pri_ff;
  logic [7:0] rdata_ff;
  logic [7:0] key_ff;
  logic key_wr_ff;
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic first_cycle_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] nxt_ctl1;
  logic [7:0] ctl1_out_ff;
  logic nxt_capt_mode;
  logic wr;
  logic capt_mode;
  logic wdog_frozen;
  logic [7:0] ctl1_wmask;
  logic [7:0] ctl3_mask;
  logic [7:0] ctl4_mask;

  assign wr = pf_req_i.wr;
  assign capt_mode = ctl4_ff[CTL4_MODE_BIT];
  // The hard option never freezes the selects.
  assign wdog_frozen = ctl2_ff[CTL2_WRST_EN_BIT] && (WDOG_OPTION != WDOG_HARD);
  // Watchdog selects are privileged and freeze; the timer select is plain.
  assign ctl1_wmask = CTL1_TIMER_MASK
                    | ((pf_req_i.priv && !wdog_frozen) ? CTL1_WDOG_MASK : BYTE_ZERO);
  // A mode write reshapes control 3 at the same edge as control 4.
  assign nxt_capt_mode = (wr && pf_req_i.addr == ADDR_CONTROL_FOUR)
                       ? pf_req_i.wdata[CTL4_MODE_BIT] : capt_mode;
  assign ctl3_mask = nxt_capt_mode ? CTL3_CAPT_MASK : CTL3_DUAL_MASK;
  assign ctl4_mask = capt_mode ? CTL4_CAPT_MASK : CTL4_DUAL_MASK;

  // ==========================================================================
  // Compare and capture/compare byte pairs
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      compare_ff <= WORD_ZERO;
    end else if (wr && pf_req_i.addr == ADDR_COMPARE_HIGH) begin
      compare_ff[15:8] <= pf_req_i.wdata;
    end else if (wr && pf_req_i.addr == ADDR_COMPARE_LOW) begin
      compare_ff[7:0] <= pf_req_i.wdata;
    end
  end

  // In capture mode a capture from the counting logic wins over a software write.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      capcmp_ff <= WORD_ZERO;
    end else if (capture_load_i && capt_mode) begin
      capcmp_ff <= capture_value_i;
    end else if (wr && pf_req_i.addr == ADDR_CAPCMP_HIGH) begin
      capcmp_ff[15:8] <= pf_req_i.wdata;
    end else if (wr && pf_req_i.addr == ADDR_CAPCMP_LOW) begin
      capcmp_ff[7:0] <= pf_req_i.wdata;
    end
  end

  // ==========================================================================
  // Watchdog key
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_ff <= BYTE_ZERO;
      key_wr_ff <= 1'b0;
    end else begin
      key_wr_ff <= wr && pf_req_i.addr == ADDR_WDOG_KEY;
      if (wr && pf_req_i.addr == ADDR_WDOG_KEY) begin
        key_ff <= pf_req_i.wdata;
      end
    end
  end

  // ==========================================================================
  // Control register 1
  // ==========================================================================
  always_comb begin
    nxt_ctl1 = ctl1_ff;
    if (wr && pf_req_i.addr == ADDR_CONTROL_ONE) begin
      nxt_ctl1 = (ctl1_ff & ~ctl1_wmask) | (pf_req_i.wdata & ctl1_wmask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl1_ff <= BYTE_ZERO;
    end else begin
      ctl1_ff <= nxt_ctl1;
    end
  end

  // The hard option ignores the watchdog input select MSB on the output only.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl1_out_ff <= BYTE_ZERO;
    end else if (WDOG_OPTION == WDOG_HARD) begin
      ctl1_out_ff <= nxt_ctl1 & ~(8'h01 << CTL1_WSEL_MSB_BIT);
    end else begin
      ctl1_out_ff <= nxt_ctl1;
    end
  end

  // ==========================================================================
  // Control register 2
  // ==========================================================================
  // The reset enable is privileged and set-only; enables are plain read/write;
  // flags are clear-only and a hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl2_ff[CTL2_WRST_EN_BIT] <= 1'b0;
      ctl2_ff[CTL2_WIRQ_EN_BIT] <= 1'b0;
      ctl2_ff[CTL2_TIRQ_EN_BIT] <= 1'b0;
      ctl2_ff[CTL2_TIRQ_FLAG_BIT] <= 1'b0;
      ctl2_ff[2:1] <= 2'h0;
      ctl2_ff[CTL2_SOFT_CLR_BIT] <= 1'b0;
    end else begin
      if (wr && pf_req_i.addr == ADDR_CONTROL_TWO) begin
        if (pf_req_i.priv && pf_req_i.wdata[CTL2_WRST_EN_BIT]) begin
          ctl2_ff[CTL2_WRST_EN_BIT] <= 1'b1;
        end
        ctl2_ff[CTL2_WIRQ_EN_BIT] <= pf_req_i.wdata[CTL2_WIRQ_EN_BIT];
        ctl2_ff[CTL2_TIRQ_EN_BIT] <= pf_req_i.wdata[CTL2_TIRQ_EN_BIT];
      end
      if (events_i.timer_overflow) begin
        ctl2_ff[CTL2_TIRQ_FLAG_BIT] <= 1'b1;
      end else if (wr && pf_req_i.addr == ADDR_CONTROL_TWO
                   && !pf_req_i.wdata[CTL2_TIRQ_FLAG_BIT]) begin
        ctl2_ff[CTL2_TIRQ_FLAG_BIT] <= 1'b0;
      end
      // The watchdog flag is left alone by reset and takes the cause afterwards.
      if (first_cycle_ff) begin
        ctl2_ff[CTL2_WIRQ_FLAG_BIT] <= wdog_reset_cause_i;
      end else if (events_i.wdog_overflow) begin
        ctl2_ff[CTL2_WIRQ_FLAG_BIT] <= 1'b1;
      end else if (wr && pf_req_i.addr == ADDR_CONTROL_TWO
                   && !pf_req_i.wdata[CTL2_WIRQ_FLAG_BIT]) begin
        ctl2_ff[CTL2_WIRQ_FLAG_BIT] <= 1'b0;
      end
      // The soft clear is a one-cycle set-only strobe; a read in the cycle after the write sees it as one.
      ctl2_ff[CTL2_SOFT_CLR_BIT] <= wr && pf_req_i.addr == ADDR_CONTROL_TWO
                                   && pf_req_i.wdata[CTL2_SOFT_CLR_BIT];
    end
  end

  // The watchdog flag is not cleared by reset: in the first cycle after reset
  // it takes the reset cause, so software can tell a watchdog reset apart.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      first_cycle_ff <= 1'b1;
    end else begin
      first_cycle_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers 3 and 4
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl3_ff <= BYTE_ZERO;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!ctl3_mask[i]) begin
          ctl3_ff[i] <= 1'b0;
        end else if (CTL3_FLAG_MASK[i]) begin
          if ((i == 7 && events_i.edge_event) || (i == 6 && events_i.compare_two)
              || (i == 5 && events_i.compare_one)) begin
            ctl3_ff[i] <= 1'b1;
          end else if (wr && pf_req_i.addr == ADDR_CONTROL_THREE && !pf_req_i.wdata[i]) begin
            ctl3_ff[i] <= 1'b0;
          end
        end else if (wr && pf_req_i.addr == ADDR_CONTROL_THREE) begin
          ctl3_ff[i] <= pf_req_i.wdata[i];
        end
      end
    end
  end

  // A write is masked with the layout of the mode bit it carries, so the new mode's layout applies to that same write.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl4_ff <= BYTE_ZERO;
    end else if (wr && pf_req_i.addr == ADDR_CONTROL_FOUR) begin
      ctl4_ff <= pf_req_i.wdata
               & (pf_req_i.wdata[CTL4_MODE_BIT] ? CTL4_CAPT_MASK : CTL4_DUAL_MASK);
    end else begin
      ctl4_ff <= ctl4_ff & ctl4_mask;
    end
  end

  // ==========================================================================
  // Pin control and priority
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {pwm_pin_i, capture_reset_pin_i, event_pin_i};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc1_ff <= BYTE_ZERO;
      pc2_ff <= BYTE_ZERO;
    end else begin
      if (wr && pf_req_i.addr == ADDR_PIN_CONTROL_ONE) begin
        pc1_ff <= pf_req_i.wdata & PC1_MASK;
      end
      if (wr && pf_req_i.addr == ADDR_PIN_CONTROL_TWO) begin
        pc2_ff <= pf_req_i.wdata & PC2_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pri_ff <= BYTE_ZERO;
    end else if (wr && pf_req_i.priv && pf_req_i.addr == ADDR_PRIORITY) begin
      pri_ff <= pf_req_i.wdata & PRI_MASK;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    nxt_rdata = BYTE_ZERO;
    case (pf_req_i.addr)
      ADDR_COUNT_HIGH: nxt_rdata = timer_count_i[15:8];
      ADDR_COUNT_LOW: nxt_rdata = timer_count_i[7:0];
      ADDR_COMPARE_HIGH: nxt_rdata = compare_ff[15:8];
      ADDR_COMPARE_LOW: nxt_rdata = compare_ff[7:0];
      ADDR_CAPCMP_HIGH: nxt_rdata = capcmp_ff[15:8];
      ADDR_CAPCMP_LOW: nxt_rdata = capcmp_ff[7:0];
      ADDR_WDOG_COUNT_HIGH: nxt_rdata = wdog_count_i[15:8];
      ADDR_WDOG_COUNT_LOW: nxt_rdata = wdog_count_i[7:0];
      ADDR_CONTROL_ONE: nxt_rdata = ctl1_ff;
      ADDR_CONTROL_TWO: nxt_rdata = ctl2_ff;
      ADDR_CONTROL_THREE: nxt_rdata = ctl3_ff;
      ADDR_CONTROL_FOUR: nxt_rdata = ctl4_ff;
      ADDR_PIN_CONTROL_ONE: nxt_rdata = {4'h0, pin_sync_ff[0], pc1_ff[2:0]};
      ADDR_PIN_CONTROL_TWO: nxt_rdata = {pin_sync_ff[2], pc2_ff[6:4],
                                         pin_sync_ff[1], pc2_ff[2:0]};
      ADDR_PRIORITY: nxt_rdata = pri_ff;
      default: nxt_rdata = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= BYTE_ZERO;
    end else if (pf_req_i.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign pf_rdata_o = rdata_ff;
  assign compare_value_o = compare_ff;
  assign capture_compare_o = capcmp_ff;
  assign control_one_o = ctl1_out_ff;
  assign control_two_o = ctl2_ff;
  assign control_three_o = ctl3_ff;
  assign control_four_o = ctl4_ff;
  assign priority_o = pri_ff;
  assign timer_soft_clear_o = ctl2_ff[CTL2_SOFT_CLR_BIT];
  assign wdog_key_write_o = key_wr_ff;
  assign wdog_key_o = key_ff;
  assign event_pin_ctrl_o = pc1_ff[2:0];
  assign pwm_pin_ctrl_o = pc2_ff[6:4];
  assign capture_reset_pin_ctrl_o = pc2_ff[2:0];

endmodule

// file: src/timer_regs_pkg.sv
// Package with the register map, field positions and types of the timer register bank.
package timer_regs_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [15:0] ADDR_COUNT_HIGH = 16'h1040;
  localparam logic [15:0] ADDR_COUNT_LOW = 16'h1041;
  localparam logic [15:0] ADDR_COMPARE_HIGH = 16'h1042;
  localparam logic [15:0] ADDR_COMPARE_LOW = 16'h1043;
  localparam logic [15:0] ADDR_CAPCMP_HIGH = 16'h1044;
  localparam logic [15:0] ADDR_CAPCMP_LOW = 16'h1045;
  localparam logic [15:0] ADDR_WDOG_COUNT_HIGH = 16'h1046;
  localparam logic [15:0] ADDR_WDOG_COUNT_LOW = 16'h1047;
  localparam logic [15:0] ADDR_WDOG_KEY = 16'h1048;
  localparam logic [15:0] ADDR_CONTROL_ONE = 16'h1049;
  localparam logic [15:0] ADDR_CONTROL_TWO = 16'h104a;
  localparam logic [15:0] ADDR_CONTROL_THREE = 16'h104b;
  localparam logic [15:0] ADDR_CONTROL_FOUR = 16'h104c;
  localparam logic [15:0] ADDR_PIN_CONTROL_ONE = 16'h104d;
  localparam logic [15:0] ADDR_PIN_CONTROL_TWO = 16'h104e;
  localparam logic [15:0] ADDR_PRIORITY = 16'h104f;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTL1_TAP_BIT = 7;
  localparam int CTL1_WSEL_MSB_BIT = 6;
  localparam int CTL2_WRST_EN_BIT = 7;
  localparam int CTL2_WIRQ_EN_BIT = 6;
  localparam int CTL2_WIRQ_FLAG_BIT = 5;
  localparam int CTL2_TIRQ_EN_BIT = 4;
  localparam int CTL2_TIRQ_FLAG_BIT = 3;
  localparam int CTL2_SOFT_CLR_BIT = 0;
  localparam int CTL4_MODE_BIT = 7;
  localparam int PRI_STEST_BIT = 7;
  localparam int PRI_PRIO_BIT = 6;

  // Writable masks of control registers 1, 3 and 4 in each mode, and of the pin control and priority registers.
  localparam logic [7:0] CTL1_TIMER_MASK = 8'h07;
  localparam logic [7:0] CTL1_WDOG_MASK = 8'hf0;
  localparam logic [7:0] CTL3_DUAL_MASK = 8'he7;
  localparam logic [7:0] CTL3_CAPT_MASK = 8'ha5;
  localparam logic [7:0] CTL3_FLAG_MASK = 8'he0;
  localparam logic [7:0] CTL4_DUAL_MASK = 8'hff;
  localparam logic [7:0] CTL4_CAPT_MASK = 8'hd5;
  localparam logic [7:0] PC1_MASK = 8'h07;
  localparam logic [7:0] PC2_MASK = 8'h77;
  localparam logic [7:0] PRI_MASK = 8'hc0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Watchdog options.
  typedef enum logic [1:0] {
    WDOG_STANDARD,
    WDOG_HARD,
    WDOG_SIMPLE
  } wdog_option_t;

  // One peripheral-file access from the CPU.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic priv;
  } pf_req_t;

  // Events raised by the counting logic outside this bank.
  typedef struct packed {
    logic wdog_overflow;
    logic timer_overflow;
    logic edge_event;
    logic compare_two;
    logic compare_one;
  } timer_events_t;

  // Pin control view for one timer pin.
  typedef struct packed {
    logic data_out;
    logic function_sel;
    logic direction;
  } pin_ctrl_t;

endpackage

// file: verif/timer_watchdog_regfile_properties.sv
// Concurrent checks on the ports of the timer register bank.
`timescale 1ns/1ps

module timer_watchdog_regfile_properties
  import timer_regs_pkg::*;
#(
  parameter wdog_option_t WDOG_OPTION = WDOG_STANDARD
) (
  // Clock, reset and access.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pf_req_t pf_req_i,
  input wire timer_events_t events_i,
  // Register views.
  input wire logic [7:0] pf_rdata_o,
  input wire logic [15:0] compare_value_o,
  input wire logic [7:0] control_one_o,
  input wire logic [7:0] control_two_o,
  input wire logic [7:0] control_three_o,
  input wire logic [7:0] control_four_o,
  input wire logic [7:0] priority_o,
  input wire logic timer_soft_clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic rst_seen_ff;
  logic wr_one;
  logic wr_two;
  assign wr_one = pf_req_i.wr && pf_req_i.addr == ADDR_CONTROL_ONE;
  assign wr_two = pf_req_i.wr && pf_req_i.addr == ADDR_CONTROL_TWO;
  always_ff @(posedge clk_i) begin
    rst_seen_ff <= !rst_n_i;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_priv_ignore;
    wr_one && !pf_req_i.priv |=> control_one_o[7:4] == $past(control_one_o[7:4]);
  endproperty
  a_priv_ignore: assert property (p_priv_ignore)
    else $error("privileged watchdog selects changed without privilege");
  property p_prio_priv;
    pf_req_i.wr && pf_req_i.addr == ADDR_PRIORITY && !pf_req_i.priv |=> $stable(priority_o);
  endproperty
  a_prio_priv: assert property (p_prio_priv)
    else $error("priority register changed without privilege");
  property p_rst_enable_sticky;
    control_two_o[7] |=> control_two_o[7];
  endproperty
  a_rst_enable_sticky: assert property (p_rst_enable_sticky)
    else $error("watchdog reset enable cleared without reset");
  property p_freeze;
    control_two_o[7] && WDOG_OPTION != WDOG_HARD |=> $stable(control_one_o[7:4]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("watchdog selects changed while frozen");
  property p_hard_msb;
    WDOG_OPTION == WDOG_HARD |-> !control_one_o[6];
  endproperty
  a_hard_msb: assert property (p_hard_msb)
    else $error("input select msb active in hard option");
  property p_reset_values;
    rst_seen_ff |-> control_one_o == 8'h00 && control_three_o == 8'h00 &&
      control_four_o == 8'h00 && priority_o == 8'h00 && control_two_o[7] == 1'b0 &&
      compare_value_o == 16'h0000;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register not at reset value after reset");
  property p_soft_pulse;
    wr_two && pf_req_i.wdata[0] |=> timer_soft_clear_o ##1 !timer_soft_clear_o;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("soft clear is not a single pulse");
  property p_flag_clear_only;
    !control_two_o[3] && !events_i.timer_overflow |=> !control_two_o[3];
  endproperty
  a_flag_clear_only: assert property (p_flag_clear_only)
    else $error("overflow flag set without an event");
  property p_flag_event;
    events_i.timer_overflow |=> control_two_o[3];
  endproperty
  a_flag_event: assert property (p_flag_event)
    else $error("overflow flag not set by event");
  property p_capture_layout;
    control_four_o[7] |-> (control_four_o & ~CTL4_CAPT_MASK) == 8'h00 &&
      (control_three_o & ~CTL3_CAPT_MASK) == 8'h00;
  endproperty
  a_capture_layout: assert property (p_capture_layout)
    else $error("dual compare bits live in capture mode");
  property p_read_high;
    pf_req_i.rd && pf_req_i.addr == ADDR_COMPARE_HIGH |=>
      pf_rdata_o == $past(compare_value_o[15:8]);
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("compare high byte read wrong");
endmodule

// file: verif/tb.sv
// Self-checking testbench of the timer register bank.
`timescale 1ns/1ps

module tb;
  import timer_regs_pkg::*;

  typedef struct {logic [15:0] a; logic [7:0] d; logic p; logic [7:0] e;} row_t;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pf_req_t pf_req_i = '0;
  logic [15:0] timer_count_i = 16'ha5c3;
  logic [15:0] capture_value_i = 16'h0000;
  logic capture_load_i = 1'b0;
  logic [15:0] wdog_count_i = 16'h5a3c;
  timer_events_t events_i = '0;
  logic wdog_reset_cause_i = 1'b1;
  logic event_pin_i = 1'b0;
  logic pwm_pin_i = 1'b0;
  logic capture_reset_pin_i = 1'b0;
  logic [7:0] pf_rdata_o;
  logic [15:0] compare_value_o;
  logic [15:0] capture_compare_o;
  logic [7:0] control_one_o;
  logic [7:0] control_two_o;
  logic [7:0] control_three_o;
  logic [7:0] control_four_o;
  logic [7:0] priority_o;
  logic timer_soft_clear_o;
  logic wdog_key_write_o;
  logic [7:0] wdog_key_o;
  pin_ctrl_t event_pin_ctrl_o;
  pin_ctrl_t pwm_pin_ctrl_o;
  pin_ctrl_t capture_reset_pin_ctrl_o;
  logic [7:0] hard_ctl1;
  int err_total = 0;
  int check_count = 0;

  row_t rows [16] = '{
    '{16'h1040, 8'hff, 1'b1, 8'ha5}, '{16'h1041, 8'hff, 1'b1, 8'hc3},
    '{16'h1046, 8'hff, 1'b1, 8'h5a}, '{16'h1047, 8'hff, 1'b1, 8'h3c},
    '{16'h1042, 8'h12, 1'b0, 8'h12}, '{16'h1043, 8'h34, 1'b0, 8'h34},
    '{16'h1049, 8'hff, 1'b0, 8'h07}, '{16'h1049, 8'hff, 1'b1, 8'hf7},
    '{16'h104f, 8'hff, 1'b0, 8'h00}, '{16'h104f, 8'hff, 1'b1, 8'hc0},
    '{16'h104a, 8'h50, 1'b1, 8'h50}, '{16'h104c, 8'h7f, 1'b0, 8'h7f},
    '{16'h104b, 8'hff, 1'b0, 8'h07}, '{16'h104d, 8'hff, 1'b0, 8'h07},
    '{16'h104e, 8'hff, 1'b0, 8'h77}, '{16'h1050, 8'hff, 1'b1, 8'h00}
  };

  timer_watchdog_regfile #(.WDOG_OPTION(WDOG_STANDARD)) DUT (.*);

  // A second bank in the hard watchdog option shares all stimulus.
  timer_watchdog_regfile #(.WDOG_OPTION(WDOG_HARD)) DUT_HARD (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pf_req_i(pf_req_i), .pf_rdata_o(),
    .timer_count_i(timer_count_i), .capture_value_i(capture_value_i),
    .capture_load_i(capture_load_i), .wdog_count_i(wdog_count_i), .events_i(events_i),
    .wdog_reset_cause_i(wdog_reset_cause_i), .event_pin_i(event_pin_i),
    .pwm_pin_i(pwm_pin_i), .capture_reset_pin_i(capture_reset_pin_i),
    .compare_value_o(), .capture_compare_o(), .control_one_o(hard_ctl1),
    .control_two_o(), .control_three_o(), .control_four_o(), .priority_o(),
    .timer_soft_clear_o(), .wdog_key_write_o(), .wdog_key_o(), .event_pin_ctrl_o(),
    .pwm_pin_ctrl_o(), .capture_reset_pin_ctrl_o()
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic p);
    @(negedge clk_i);
    pf_req_i = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, priv: p};
    @(negedge clk_i);
    pf_req_i.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    pf_req_i.addr = a;
    pf_req_i.rd = 1'b1;
    @(negedge clk_i);
    pf_req_i.rd = 1'b0;
    chk({8'h00, pf_rdata_o}, {8'h00, e});
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ADDR_CONTROL_ONE + 16'(i), i == 1 ? 8'h20 : 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].p);
      rd(rows[i].a, rows[i].e);
    end
    chk(compare_value_o, 16'h1234);
    // All event sources pulse together for one cycle.
    @(negedge clk_i);
    events_i = 5'h1f;
    @(negedge clk_i);
    events_i = '0;
    rd(ADDR_CONTROL_TWO, 8'h78);
    rd(ADDR_CONTROL_THREE, 8'he7);
    wr(ADDR_CONTROL_THREE, 8'h00, 1'b0);
    rd(ADDR_CONTROL_THREE, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h50, 1'b0);
    rd(ADDR_CONTROL_TWO, 8'h50);
    wr(ADDR_CONTROL_TWO, 8'h51, 1'b0);
    chk({15'h0000, timer_soft_clear_o}, 16'h0001);
    @(negedge clk_i);
    chk({15'h0000, timer_soft_clear_o}, 16'h0000);
    rd(ADDR_CONTROL_TWO, 8'h50);
    wr(ADDR_CONTROL_TWO, 8'hd0, 1'b0);
    rd(ADDR_CONTROL_TWO, 8'h50);
    wr(ADDR_CONTROL_TWO, 8'hd0, 1'b1);
    rd(ADDR_CONTROL_TWO, 8'hd0);
    wr(ADDR_CONTROL_TWO, 8'h50, 1'b1);
    rd(ADDR_CONTROL_TWO, 8'hd0);
    wr(ADDR_CONTROL_ONE, 8'h00, 1'b1);
    rd(ADDR_CONTROL_ONE, 8'hf0);
    chk({8'h00, hard_ctl1}, 16'h0000);
    wr(ADDR_CONTROL_ONE, 8'hf0, 1'b1);
    rd(ADDR_CONTROL_ONE, 8'hf0);
    chk({8'h00, hard_ctl1}, 16'h00b0);
    wr(ADDR_WDOG_KEY, 8'h55, 1'b0);
    chk({7'h00, wdog_key_write_o, wdog_key_o}, 16'h0155);
    @(negedge clk_i);
    chk({7'h00, wdog_key_write_o, wdog_key_o}, 16'h0055);
    // Pin levels pass a two-flop synchroniser before they read back.
    event_pin_i = 1'b1;
    pwm_pin_i = 1'b1;
    capture_reset_pin_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rd(ADDR_PIN_CONTROL_TWO, 8'hff);
    rd(ADDR_PIN_CONTROL_ONE, 8'h0f);
    chk({7'h00, event_pin_ctrl_o, pwm_pin_ctrl_o, capture_reset_pin_ctrl_o}, 16'h01ff);
    wr(ADDR_CONTROL_FOUR, 8'hff, 1'b0);
    rd(ADDR_CONTROL_FOUR, 8'hd5);
    wr(ADDR_CONTROL_THREE, 8'hff, 1'b0);
    rd(ADDR_CONTROL_THREE, 8'h05);
    capture_value_i = 16'habcd;
    capture_load_i = 1'b1;
    @(negedge clk_i);
    capture_load_i = 1'b0;
    rd(ADDR_CAPCMP_HIGH, 8'hab);
    rd(ADDR_CAPCMP_LOW, 8'hcd);
    chk(capture_compare_o, 16'habcd);
    // A second reset in mid-run, now without a watchdog cause.
    wdog_reset_cause_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(ADDR_CONTROL_TWO, 8'h00);
    rd(ADDR_CONTROL_ONE, 8'h00);
    rd(ADDR_CONTROL_FOUR, 8'h00);
    report_and_stop();
  end
endmodule

bind timer_watchdog_regfile timer_watchdog_regfile_properties #(
  .WDOG_OPTION(WDOG_OPTION)
) u_props (.*);
